// ### common/adb_pkg.sv
// package with constants and carrier types for the shared data-bus pin block
package adb_pkg;

  // ****************************************************************
  // widths and depths
  // ****************************************************************
  localparam int DATA_W        = 16;
  localparam int FIFO_DEPTH    = 32;
  localparam int RESULT_BITS   = 16;
  localparam int CTRL_W        = 8;

  // ****************************************************************
  // pin positions on the shared bus
  // ****************************************************************
  localparam int BIT_SEL_A     = 0;
  localparam int BIT_SEL_B     = 1;
  localparam int BIT_SEL_C     = 2;
  localparam int BIT_CHAIN_C   = 3;
  localparam int BIT_CHAIN_B   = 4;
  localparam int BIT_CHAIN_A   = 5;
  localparam int BIT_SCLK      = 6;
  localparam int BIT_HBF       = 7;
  localparam int BIT_CHAIN_EN  = 7;
  localparam int BIT_DOUT_A    = 8;
  localparam int BIT_DOUT_B    = 9;
  localparam int BIT_DOUT_C    = 10;
  localparam int BIT_CTRL_LSB  = 8;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;

  // ****************************************************************
  // carrier types
  // ****************************************************************
  typedef struct packed {
    logic csN;
    logic rdN;
    logic wrN;
    logic serialParallelSelect;
    logic wordByteSelect;
  } adb_ctl_t;

  typedef enum logic [1:0] {
    ST_IDLE      = 2'b00,
    ST_PAR_READ  = 2'b01,
    ST_SER_LOAD  = 2'b11,
    ST_SER_SHIFT = 2'b10
  } adb_state_t;

endpackage

// ### src/adb_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module adb_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;
  logic [WIDTH-1:0] stage3_q;
  logic [WIDTH-1:0] syncOut_d;
  logic [WIDTH-1:0] syncOut_q;

  // a bit moves only once stages two and three agree
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      syncOut_d[i] = (stage2_q[i] == stage3_q[i]) ? stage3_q[i] : syncOut_q[i];
    end
  end

  // stage one feeds stage two only, to keep metastability contained
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage1_q  <= '0;
      stage2_q  <= '0;
      stage3_q  <= '0;
      syncOut_q <= '0;
    end else begin
      stage1_q  <= asyncIn;
      stage2_q  <= stage1_q;
      stage3_q  <= stage2_q;
      syncOut_q <= syncOut_d;
    end
  end

  assign syncOut = syncOut_q;

endmodule

// ### src/adb_fifo.sv
// result FIFO with valid/ready on both sides
`timescale 1ns/1ps
module adb_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    wrPtr_d;
  logic [AW-1:0]    rdPtr_q;
  logic [AW-1:0]    rdPtr_d;
  logic [AW:0]      count_q;
  logic [AW:0]      count_d;
  logic             inReady_q;
  logic             inReady_d;
  logic             push;
  logic             pop;

  assign push     = inValid && inReady_q;
  assign pop      = outReady && (count_q != '0);
  assign outValid = (count_q != '0);
  assign outData  = mem[rdPtr_q];
  assign inReady  = inReady_q;

  // pointer wrap assumes a power-of-two depth
  always_comb begin
    wrPtr_d   = push ? wrPtr_q + 1'b1 : wrPtr_q;
    rdPtr_d   = pop ? rdPtr_q + 1'b1 : rdPtr_q;
    count_d   = count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    inReady_d = (count_d != (AW+1)'(DEPTH));
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wrPtr_q   <= '0;
      rdPtr_q   <= '0;
      count_q   <= '0;
      inReady_q <= 1'b0;
    end else begin
      wrPtr_q   <= wrPtr_d;
      rdPtr_q   <= rdPtr_d;
      count_q   <= count_d;
      inReady_q <= inReady_d;
    end
  end

  // storage needs no reset
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

endmodule

// ### src/adb_pin_mux.sv
// shared data-bus pin functions: parallel word/byte port, serial port, chain
`timescale 1ns/1ps
module adb_pin_mux #(
  parameter int RESULT_BITS = adb_pkg::RESULT_BITS,
  parameter int FIFO_DEPTH  = adb_pkg::FIFO_DEPTH
) (
  input  wire logic                        sys_clk,
  input  wire logic                        sys_rst,
  // pin side
  input  wire logic                        csN,
  input  wire logic                        rdN,
  input  wire logic                        wrN,
  input  wire logic                        serialParallelSelect,
  input  wire logic                        wordByteSelect,
  input  wire logic [adb_pkg::DATA_W-1:0]  dbIn,
  output logic      [adb_pkg::DATA_W-1:0]  dbOut,
  output logic      [adb_pkg::DATA_W-1:0]  dbOe,
  // user side
  input  wire logic [adb_pkg::DATA_W-1:0]  resultData,
  input  wire logic                        resultValid,
  output logic                             resultReady,
  output logic      [adb_pkg::CTRL_W-1:0]  ctrlData,
  output logic                             ctrlWrite,
  output logic                             serialActive,
  output logic                             chainActive
);

  // ****************************************************************
  // helpers
  // ****************************************************************

  // narrow variants clear bit 15, and for 12 bits also bits 13 and 12; bit 14 passes through
  function automatic logic [15:0] fitWidth(input logic [15:0] w);
    logic [15:0] r;
    r = w;
    if (RESULT_BITS == 14) begin
      r[15] = 1'b0;
    end else if (RESULT_BITS == 12) begin
      r[15] = 1'b0;
      r[13] = 1'b0;
      r[12] = 1'b0;
    end
    return r;
  endfunction

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  adb_pkg::adb_ctl_t             ctlRaw;
  adb_pkg::adb_ctl_t             ctlInv;
  adb_pkg::adb_ctl_t             ctl;
  logic [adb_pkg::DATA_W-1:0]    dbS;

  // strobes cross inverted so the all-zero synchroniser reset reads as idle-high pins,
  // otherwise a phantom read would drive the bus right after reset
  assign ctlRaw = '{csN: !csN, rdN: !rdN, wrN: !wrN,
                    serialParallelSelect: serialParallelSelect,
                    wordByteSelect: wordByteSelect};
  assign ctl    = '{csN: !ctlInv.csN, rdN: !ctlInv.rdN, wrN: !ctlInv.wrN,
                    serialParallelSelect: ctlInv.serialParallelSelect,
                    wordByteSelect: ctlInv.wordByteSelect};

  adb_sync #(.WIDTH($bits(adb_pkg::adb_ctl_t))) uCtlSync (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .asyncIn (ctlRaw),
    .syncOut (ctlInv)
  );

  adb_sync #(.WIDTH(adb_pkg::DATA_W)) uBusSync (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .asyncIn (dbIn),
    .syncOut (dbS)
  );

  // ****************************************************************
  // result buffer
  // ****************************************************************
  logic [adb_pkg::DATA_W-1:0] headData;
  logic                       headValid;
  logic                       pop;

  adb_fifo #(.WIDTH(adb_pkg::DATA_W), .DEPTH(FIFO_DEPTH)) uFifo (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .inData   (resultData),
    .inValid  (resultValid),
    .inReady  (resultReady),
    .outData  (headData),
    .outValid (headValid),
    .outReady (pop)
  );

  // ****************************************************************
  // decoded pin functions
  // ****************************************************************
  logic        serMode;
  logic        byteMode;
  logic        readAct;
  logic        writeAct;
  logic        selA;
  logic        selB;
  logic        selC;
  logic        chainEn;
  logic        sclkFall;
  logic        csFall;
  logic [15:0] headWord;
  logic        sclkPrev_q;
  logic        csPrev_q;

  // select low means parallel, high means serial
  assign serMode  = ctl.serialParallelSelect;
  assign byteMode = ctl.wordByteSelect && !serMode;
  assign readAct  = !ctl.csN && !ctl.rdN && !serMode;
  // a simultaneous read wins and the write is ignored
  assign writeAct = !ctl.csN && !ctl.wrN && !serMode && ctl.rdN;
  assign selA     = dbS[adb_pkg::BIT_SEL_A];
  assign selB     = dbS[adb_pkg::BIT_SEL_B];
  assign selC     = dbS[adb_pkg::BIT_SEL_C];
  // unused chain pins are grounded by the board, so a low here is trusted
  assign chainEn  = serMode && dbS[adb_pkg::BIT_CHAIN_EN];
  assign sclkFall = sclkPrev_q && !dbS[adb_pkg::BIT_SCLK];
  assign csFall   = csPrev_q && !ctl.csN;
  assign headWord = headValid ? fitWidth(headData) : adb_pkg::WORD_RST;

  // ****************************************************************
  // state
  // ****************************************************************
  adb_pkg::adb_state_t  state_q;
  adb_pkg::adb_state_t  state_d;
  logic [15:0]          word_q;
  logic [15:0]          word_d;
  logic                 byteSecond_q;
  logic                 byteSecond_d;
  logic                 hbf_q;
  logic                 hbf_d;
  logic [15:0]          shA_q;
  logic [15:0]          shA_d;
  logic [15:0]          shB_q;
  logic [15:0]          shB_d;
  logic [15:0]          shC_q;
  logic [15:0]          shC_d;
  logic [1:0]           loadIdx_q;
  logic [1:0]           loadIdx_d;
  logic                 wrPrev_q;
  logic [7:0]           wrLatch_q;
  logic [7:0]           wrLatch_d;
  logic [7:0]           ctrl_q;
  logic [7:0]           ctrl_d;
  logic                 ctrlStb_q;
  logic                 ctrlStb_d;
  logic [15:0]          dbOut_q;
  logic [15:0]          dbOut_d;
  logic [15:0]          dbOe_q;
  logic [15:0]          dbOe_d;
  logic                 serAct_q;
  logic                 chainAct_q;

  // ****************************************************************
  // transfer sequencer
  // ****************************************************************

  // the head word is sampled at read start and popped only at read end,
  // so a slow read strobe still sees one stable result
  always_comb begin
    state_d      = state_q;
    word_d       = word_q;
    byteSecond_d = byteSecond_q;
    hbf_d        = hbf_q;
    shA_d        = shA_q;
    shB_d        = shB_q;
    shC_d        = shC_q;
    loadIdx_d    = loadIdx_q;
    pop          = 1'b0;
    unique case (state_q)
      adb_pkg::ST_IDLE: begin
        if (readAct) begin
          state_d = adb_pkg::ST_PAR_READ;
          word_d  = headWord;
          if (!byteSecond_q) begin
            hbf_d = dbS[adb_pkg::BIT_HBF];
          end
        end else if (serMode && csFall) begin
          state_d      = adb_pkg::ST_SER_LOAD;
          loadIdx_d    = 2'd0;
          byteSecond_d = 1'b0;
        end
      end
      adb_pkg::ST_PAR_READ: begin
        if (!readAct) begin
          state_d = adb_pkg::ST_IDLE;
          if (!byteMode || byteSecond_q) begin
            pop          = headValid;
            byteSecond_d = 1'b0;
          end else begin
            byteSecond_d = 1'b1;
          end
        end
      end
      adb_pkg::ST_SER_LOAD: begin
        // one result per enabled output, A then B then C
        loadIdx_d = loadIdx_q + 2'd1;
        if (loadIdx_q == 2'd0 && selA) begin
          shA_d = headWord;
          pop   = headValid;
        end else if (loadIdx_q == 2'd1 && selB) begin
          shB_d = headWord;
          pop   = headValid;
        end else if (loadIdx_q == 2'd2 && selC) begin
          shC_d = headWord;
          pop   = headValid;
        end
        if (loadIdx_q == 2'd2) begin
          state_d = adb_pkg::ST_SER_SHIFT;
        end
        if (ctl.csN) begin
          state_d = adb_pkg::ST_IDLE;
        end
      end
      adb_pkg::ST_SER_SHIFT: begin
        if (ctl.csN) begin
          state_d = adb_pkg::ST_IDLE;
        end else if (sclkFall) begin
          // chain inputs follow our own bits; zeros when chaining is off
          shA_d = {shA_q[14:0], chainEn & dbS[adb_pkg::BIT_CHAIN_A]};
          shB_d = {shB_q[14:0], chainEn & dbS[adb_pkg::BIT_CHAIN_B]};
          shC_d = {shC_q[14:0], chainEn & dbS[adb_pkg::BIT_CHAIN_C]};
        end
      end
    endcase
    // entering serial mode mid pair restarts the byte sequence
    if (serMode && state_q == adb_pkg::ST_IDLE && !csFall) begin
      byteSecond_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q      <= adb_pkg::ST_IDLE;
      word_q       <= adb_pkg::WORD_RST;
      byteSecond_q <= 1'b0;
      hbf_q        <= 1'b0;
      shA_q        <= adb_pkg::WORD_RST;
      shB_q        <= adb_pkg::WORD_RST;
      shC_q        <= adb_pkg::WORD_RST;
      loadIdx_q    <= 2'd0;
    end else begin
      state_q      <= state_d;
      word_q       <= word_d;
      byteSecond_q <= byteSecond_d;
      hbf_q        <= hbf_d;
      shA_q        <= shA_d;
      shB_q        <= shB_d;
      shC_q        <= shC_d;
      loadIdx_q    <= loadIdx_d;
    end
  end

  // ****************************************************************
  // control register write
  // ****************************************************************

  // the upper lines are latched while the write is low and committed at its end
  always_comb begin
    wrLatch_d = writeAct ? dbS[15:adb_pkg::BIT_CTRL_LSB] : wrLatch_q;
    ctrl_d    = ctrl_q;
    ctrlStb_d = 1'b0;
    if (wrPrev_q && !writeAct) begin
      ctrl_d    = wrLatch_q;
      ctrlStb_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wrLatch_q  <= adb_pkg::CTRL_RST;
      ctrl_q     <= adb_pkg::CTRL_RST;
      ctrlStb_q  <= 1'b0;
      wrPrev_q   <= 1'b0;
      sclkPrev_q <= 1'b0;
      csPrev_q   <= 1'b1;
    end else begin
      wrLatch_q  <= wrLatch_d;
      ctrl_q     <= ctrl_d;
      ctrlStb_q  <= ctrlStb_d;
      wrPrev_q   <= writeAct;
      sclkPrev_q <= dbS[adb_pkg::BIT_SCLK];
      csPrev_q   <= ctl.csN;
    end
  end

  // ****************************************************************
  // pin drivers
  // ****************************************************************

  // enables are registered, so pins turn around one cycle after the synchronised strobes and state
  always_comb begin
    dbOut_d = '0;
    dbOe_d  = '0;
    if (state_q == adb_pkg::ST_PAR_READ && readAct) begin
      if (byteMode) begin
        // byte lanes on the upper lines only; bit 7 stays an input
        dbOut_d[15:8] = (hbf_q ^ byteSecond_q) ? word_q[15:8] : word_q[7:0];
        dbOe_d[15:8]  = 8'hff;
      end else begin
        dbOut_d = word_q;
        dbOe_d  = 16'hffff;
      end
    end else if (serMode && !ctl.csN) begin
      dbOut_d[adb_pkg::BIT_DOUT_A] = shA_q[15];
      dbOut_d[adb_pkg::BIT_DOUT_B] = shB_q[15];
      dbOut_d[adb_pkg::BIT_DOUT_C] = shC_q[15];
      dbOe_d[adb_pkg::BIT_DOUT_A]  = selA;
      dbOe_d[adb_pkg::BIT_DOUT_B]  = selB;
      dbOe_d[adb_pkg::BIT_DOUT_C]  = selC;
    end
    // bits 11..15 are grounded by the board in serial, so never driven
    if (ctl.csN) begin
      dbOe_d = '0;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dbOut_q    <= '0;
      dbOe_q     <= '0;
      serAct_q   <= 1'b0;
      chainAct_q <= 1'b0;
    end else begin
      dbOut_q    <= dbOut_d;
      dbOe_q     <= dbOe_d;
      serAct_q   <= serMode;
      chainAct_q <= chainEn;
    end
  end

  assign dbOut        = dbOut_q;
  assign dbOe         = dbOe_q;
  assign ctrlData     = ctrl_q;
  assign ctrlWrite    = ctrlStb_q;
  assign serialActive = serAct_q;
  assign chainActive  = chainAct_q;

endmodule

// ### verif/adb_pin_mux_monitor.sv
// concurrent checks on the ports of the shared data-bus pin block
`timescale 1ns/1ps
module adb_pin_mux_monitor #(
  parameter int RESULT_BITS = 16,
  parameter int FIFO_DEPTH  = 32
) (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        csN,
  input wire logic        rdN,
  input wire logic        wrN,
  input wire logic        serialParallelSelect,
  input wire logic        wordByteSelect,
  input wire logic [15:0] dbIn,
  input wire logic [15:0] dbOut,
  input wire logic [15:0] dbOe,
  input wire logic [15:0] resultData,
  input wire logic        resultValid,
  input wire logic        resultReady,
  input wire logic [7:0]  ctrlData,
  input wire logic        ctrlWrite,
  input wire logic        serialActive,
  input wire logic        chainActive
);
  // ******************
  // pin-level checks
  // ******************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // eight cycles cover the four-flop synchroniser plus state and output flops
  sequence parWord;
    (!csN && !rdN && wrN && !serialParallelSelect && !wordByteSelect) [*8];
  endsequence
  sequence parByte;
    (!csN && !rdN && wrN && !serialParallelSelect && wordByteSelect) [*8];
  endsequence
  sequence serHold;
    (serialParallelSelect && !csN && $stable(dbIn[2:0])) [*8];
  endsequence

  a_word_read_drive: assert property (parWord |-> dbOe == 16'hffff)
    else $error("word read does not drive all lines");
  a_byte_upper_only: assert property (parByte |-> dbOe == 16'hff00)
    else $error("byte read drives wrong lines");
  a_idle_release: assert property (csN [*6] |-> dbOe == 16'h0000)
    else $error("bus driven while deselected");
  a_no_read_quiet: assert property ((!serialParallelSelect && rdN) [*8] |-> dbOe == 16'h0000)
    else $error("parallel lines driven without read");
  a_ser_enables: assert property (serHold |-> dbOe == {5'h00, dbIn[2:0], 8'h00})
    else $error("serial output enables do not follow selects");
  a_write_pulse: assert property (ctrlWrite |=> !ctrlWrite)
    else $error("control write pulse longer than one cycle");
  a_write_data: assert property (ctrlWrite |-> ctrlData == $past(dbIn[15:8], 8))
    else $error("control data differs from upper lines");
  a_mode_flags: assert property (serialParallelSelect [*6] |-> serialActive)
    else $error("serial mode not taken");
  a_par_flags: assert property ((!serialParallelSelect) [*6] |-> !serialActive && !chainActive)
    else $error("serial or chain flag in parallel mode");
  a_chain_flag: assert property ((serialParallelSelect && dbIn[7]) [*6] |-> chainActive)
    else $error("chain mode not taken");
endmodule

// ### verif/adb_host_model.sv
// host-side model: drives strobes, mode pins and the shared data bus
`timescale 1ns/1ps
module adb_host_model (
  input  wire logic        sys_clk,
  input  wire logic [15:0] dbOut,
  input  wire logic [15:0] dbOe,
  output logic             csN = 1'b1,
  output logic             rdN = 1'b1,
  output logic             wrN = 1'b1,
  output logic             serialParallelSelect = 1'b0,
  output logic             wordByteSelect = 1'b0,
  output logic [15:0]      dbIn
);
  logic [15:0] hostDrv = 16'h0000;
  logic [15:0] hostEn  = 16'h0000;
  logic [15:0] pat     = 16'h5a5a;

  // ******************
  // bus resolution
  // ******************
  // undriven lines flip every cycle so a stale value never passes as data
  always @(posedge sys_clk)
    pat <= ~pat;
  assign dbIn = (dbOe & dbOut) | (~dbOe & hostEn & hostDrv) | (~dbOe & ~hostEn & pat);

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // one parallel read, strobes held well past the enable latency
  task automatic parRead(input logic byteMode, input logic hbf, output logic [15:0] v,
                         output logic [15:0] oe);
    @(posedge sys_clk);
    wordByteSelect <= byteMode;
    hostDrv        <= {8'h00, hbf, 7'h00};
    hostEn         <= {8'h00, byteMode, 7'h00};
    cyc(6);
    csN <= 1'b0;
    rdN <= 1'b0;
    cyc(8);
    v  = dbOut;
    oe = dbOe;
    csN <= 1'b1;
    rdN <= 1'b1;
    cyc(8);
  endtask

  // data stays on the upper lines past the strobe rise
  task automatic parWrite(input logic [7:0] d);
    @(posedge sys_clk);
    wordByteSelect <= 1'b0;
    hostDrv        <= {d, 8'h00};
    hostEn         <= 16'hff00;
    csN            <= 1'b0;
    wrN            <= 1'b0;
    cyc(10);
    csN <= 1'b1;
    wrN <= 1'b1;
    cyc(8);
    hostEn <= 16'h0000;
  endtask

  // low byte carries selects, chain inputs and chain enable; clock idles low
  task automatic serFrame(input logic [7:0] low, output logic [16:0] a, output logic [16:0] b,
                          output logic [16:0] c, output logic [15:0] oe);
    @(posedge sys_clk);
    serialParallelSelect <= 1'b1;
    wordByteSelect       <= 1'b0;
    hostDrv              <= {8'h00, low};
    hostEn               <= 16'hf8ff;
    cyc(6);
    csN <= 1'b0;
    cyc(12);
    oe = dbOe;
    for (int i = 16; i >= 0; i--) begin
      hostDrv[6] <= 1'b1;
      cyc(4);
      a[i] = dbOut[8];
      b[i] = dbOut[9];
      c[i] = dbOut[10];
      hostDrv[6] <= 1'b0;
      cyc(4);
    end
    csN <= 1'b1;
    cyc(8);
    serialParallelSelect <= 1'b0;
    hostEn               <= 16'h0000;
  endtask
endmodule

// ### verif/tb_top.sv
// top-level bench for the shared data-bus pin block
`timescale 1ns/1ps
module tb_top;
  logic        sys_clk, sys_rst, csN, rdN, wrN, serialParallelSelect, wordByteSelect;
  logic        resultValid, resultReady, ctrlWrite, serialActive, chainActive;
  logic [15:0] dbIn, dbOut, dbOe, resultData, v, oe, w;
  logic [7:0]  ctrlData;
  logic [16:0] a, b, c;
  logic [15:0] q[$];
  int          errors = 0, compares = 0, cycles = 0, wrCnt = 0;

  adb_pin_mux #(.RESULT_BITS(16), .FIFO_DEPTH(32)) uut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .csN(csN), .rdN(rdN), .wrN(wrN),
    .serialParallelSelect(serialParallelSelect), .wordByteSelect(wordByteSelect),
    .dbIn(dbIn), .dbOut(dbOut), .dbOe(dbOe), .resultData(resultData),
    .resultValid(resultValid), .resultReady(resultReady), .ctrlData(ctrlData),
    .ctrlWrite(ctrlWrite), .serialActive(serialActive), .chainActive(chainActive));

  adb_host_model host (
    .sys_clk(sys_clk), .dbOut(dbOut), .dbOe(dbOe), .csN(csN), .rdN(rdN), .wrN(wrN),
    .serialParallelSelect(serialParallelSelect), .wordByteSelect(wordByteSelect), .dbIn(dbIn));

  // ******************
  // clock, watchdog, reporting
  // ******************
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // counting pulses catches a doubled control write
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (ctrlWrite === 1'b1)
      wrCnt <= wrCnt + 1;
    if (cycles == 5000) begin
      errors++;
      test_done();
    end
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic test_done();
    if (errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ******************
  // test sequence
  // ******************
  initial begin
    sys_rst = 1'b1;
    resultValid = 1'b0;
    resultData = 16'h0000;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("rstOe", 16'h0000, dbOe);
    repeat (5) @(posedge sys_clk);
    chk("dbOe", 16'h0000, dbOe);
    chk("ctrlData", 16'h0000, {8'h00, ctrlData});
    chk("resultReady", 16'h0001, {15'h0, resultReady});
    // fill all 32 result queue entries, then check that it refuses
    for (int i = 0; i < 32; i++) begin
      w = {8'(i) ^ 8'h5a, ~8'(i)};
      resultData  <= w;
      resultValid <= 1'b1;
      q.push_back(w);
      @(posedge sys_clk);
    end
    resultValid <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk("resultReady", 16'h0000, {15'h0, resultReady});
    host.parRead(1'b0, 1'b0, v, oe);
    chk("wordOe", 16'hffff, oe);
    chk("word", q.pop_front(), v);
    chk("relOe", 16'h0000, dbOe);
    chk("resultReady", 16'h0001, {15'h0, resultReady});
    // byte mode, high byte first then low byte first
    for (int h = 1; h >= 0; h--) begin
      w = q.pop_front();
      host.parRead(1'b1, h[0], v, oe);
      chk("byteOe", 16'hff00, oe);
      chk("byte1", {8'h00, h ? w[15:8] : w[7:0]}, {8'h00, v[15:8]});
      host.parRead(1'b1, h[0], v, oe);
      chk("byte2", {8'h00, h ? w[7:0] : w[15:8]}, {8'h00, v[15:8]});
    end
    host.parWrite(8'ha6);
    chk("ctrlData", 16'h00a6, {8'h00, ctrlData});
    chk("ctrlWrites", 16'h0001, 16'(wrCnt));
    // outputs A and B with chaining, chain input A high
    host.serFrame(8'ha3, a, b, c, oe);
    chk("serOe", 16'h0300, oe);
    chk("serA", q.pop_front(), a[16:1]);
    chk("serB", q.pop_front(), b[16:1]);
    chk("chainA", 16'h0001, {15'h0, a[0]});
    chk("chainB", 16'h0000, {15'h0, b[0]});
    // output C alone, chain off
    host.serFrame(8'h04, a, b, c, oe);
    chk("serOe", 16'h0400, oe);
    chk("serC", q.pop_front(), c[16:1]);
    chk("fillC", 16'h0000, {15'h0, c[0]});
    chk("relOe", 16'h0000, dbOe);
    test_done();
  end
endmodule

bind adb_pin_mux adb_pin_mux_monitor #(.RESULT_BITS(RESULT_BITS), .FIFO_DEPTH(FIFO_DEPTH)) mon (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .csN(csN), .rdN(rdN), .wrN(wrN),
  .serialParallelSelect(serialParallelSelect), .wordByteSelect(wordByteSelect),
  .dbIn(dbIn), .dbOut(dbOut), .dbOe(dbOe), .resultData(resultData),
  .resultValid(resultValid), .resultReady(resultReady), .ctrlData(ctrlData),
  .ctrlWrite(ctrlWrite), .serialActive(serialActive), .chainActive(chainActive));
